/* File: hdl/asl_pkg.sv */
// Package of constants for the angle strobe load host controller
// ==========================================================================
package asl_pkg;
  // ==========================================================================
  // Clock and timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int STROBE_HIGH_NS = 100;
  localparam int STROBE_GAP_NS = 2730;
  localparam int SETUP_NS = 25;
  localparam int BUSY_WAIT_NS = 2500;
  localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_GAP_CYC = (STROBE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_WAIT_CYC = (BUSY_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;
  // ==========================================================================
  // Angle word
  localparam int ANGLE_W = 12;
  localparam int POLE_W = 2;
  localparam logic [ANGLE_W-1:0] ANGLE_RST = 12'h000;
  typedef enum logic [2:0] {
    ASL_IDLE, ASL_SETUP, ASL_HIGH, ASL_BUSY_RISE, ASL_BUSY_FALL, ASL_GAP
  } asl_state_t;
endpackage

/* File: hdl/asl_angle_form.sv */
// Angle forming: pole shift and direction
`timescale 1ns/1ps
module asl_angle_form
  import asl_pkg::*;
(
  input wire logic [ANGLE_W-1:0] src_angle,
  input wire logic [POLE_W-1:0] pole_shift,
  input wire logic reverse,
  output logic [ANGLE_W-1:0] angle
);
  logic [ANGLE_W-1:0] shifted;
  always_comb begin
    // Top bits wrap away, as one electrical turn per pole pair
    shifted = src_angle << pole_shift;
    angle = reverse ? ANGLE_W'(~shifted + 12'h001) : shifted;
  end
endmodule

/* File: hdl/asl_host.sv */
// Host controller driving angle word and strobe into the converter
`timescale 1ns/1ps
module asl_host
  import asl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ANGLE_W-1:0] src_angle,
  input wire logic [POLE_W-1:0] pole_shift,
  input wire logic reverse,
  input wire logic load_req,
  output logic load_ack,
  input wire logic busy,
  output logic [ANGLE_W-1:0] angle_out,
  output logic strobe,
  output logic timeout_err
);
  // ==========================================================================
  // Types and registers
  typedef struct packed {
    asl_state_t st;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] gap;
    logic [ANGLE_W-1:0] angle;
    logic strobe;
    logic err;
  } asl_host_t;

  localparam asl_host_t HOST_RST = '{
    st: ASL_IDLE,
    cnt: 8'h00,
    gap: 8'h00,
    angle: ANGLE_RST,
    strobe: 1'b0,
    err: 1'b0
  };

  asl_host_t st_r;
  asl_host_t st_nxt;
  logic [ANGLE_W-1:0] formed;

  asl_angle_form asl_angle_form_inst (
    .src_angle(src_angle),
    .pole_shift(pole_shift),
    .reverse(reverse),
    .angle(formed)
  );

  // ==========================================================================
  // Counting helpers
  function automatic logic done(
    input logic [CNT_W-1:0] c,
    input int lim
  );
    done = c >= CNT_W'(lim - 1);
  endfunction

  // Saturates so a stuck busy cannot wrap a count back into range
  function automatic logic [CNT_W-1:0] sat_inc(
    input logic [CNT_W-1:0] c
  );
    if (c == 8'hFF) begin
      sat_inc = c;
    end else begin
      sat_inc = c + 8'h01;
    end
  endfunction

  // Busy never came or never went: flag it, not waited on forever
  function automatic asl_host_t give_up(
    input asl_host_t s
  );
    asl_host_t n;
    n = s;
    n.err = 1'b1;
    n.st = ASL_GAP;
    return n;
  endfunction

  // ==========================================================================
  // State steps
  function automatic asl_host_t step_idle(
    input asl_host_t s,
    input logic req,
    input logic [ANGLE_W-1:0] a
  );
    asl_host_t n;
    n = s;
    n.cnt = 8'h00;
    if (req) begin
      n.angle = a;
      n.err = 1'b0;
      n.st = ASL_SETUP;
    end
    return n;
  endfunction

  function automatic asl_host_t step_setup(
    input asl_host_t s
  );
    asl_host_t n;
    n = s;
    n.cnt = sat_inc(s.cnt);
    // Data settles ahead of the rising strobe edge
    if (done(s.cnt, SETUP_CYC)) begin
      n.strobe = 1'b1;
      n.cnt = 8'h00;
      n.st = ASL_HIGH;
    end
    return n;
  endfunction

  function automatic asl_host_t step_high(
    input asl_host_t s
  );
    asl_host_t n;
    n = s;
    n.cnt = sat_inc(s.cnt);
    if (done(s.cnt, STROBE_HIGH_CYC)) begin
      n.strobe = 1'b0;
      n.cnt = 8'h00;
      n.gap = 8'h00;
      n.st = ASL_BUSY_RISE;
    end
    return n;
  endfunction

  function automatic asl_host_t step_busy_rise(
    input asl_host_t s,
    input logic b
  );
    asl_host_t n;
    n = s;
    n.cnt = sat_inc(s.cnt);
    n.gap = sat_inc(s.gap);
    if (b) begin
      // Fresh timer, so a full-length busy is never cut short
      n.cnt = 8'h00;
      n.st = ASL_BUSY_FALL;
    end else if (done(s.cnt, BUSY_WAIT_CYC)) begin
      n = give_up(n);
    end
    return n;
  endfunction

  function automatic asl_host_t step_busy_fall(
    input asl_host_t s,
    input logic b
  );
    asl_host_t n;
    n = s;
    n.cnt = sat_inc(s.cnt);
    n.gap = sat_inc(s.gap);
    if (!b) begin
      n.st = ASL_GAP;
    end else if (done(s.cnt, BUSY_WAIT_CYC)) begin
      n = give_up(n);
    end
    return n;
  endfunction

  function automatic asl_host_t step_gap(
    input asl_host_t s
  );
    asl_host_t n;
    n = s;
    n.gap = sat_inc(s.gap);
    // Counted from the strobe fall, so a short busy still waits it out
    if (done(s.gap, STROBE_GAP_CYC)) begin
      n.st = ASL_IDLE;
    end
    return n;
  endfunction

  // ==========================================================================
  // Sequencer
  // Update rate for harmonic tracking is set by how often load_req comes
  assign load_ack = (st_r.st == ASL_IDLE) && load_req;

  always_comb begin
    st_nxt = st_r;
    unique case (st_r.st)
      ASL_IDLE: begin
        st_nxt = step_idle(st_r, load_req, formed);
      end
      ASL_SETUP: begin
        st_nxt = step_setup(st_r);
      end
      ASL_HIGH: begin
        st_nxt = step_high(st_r);
      end
      ASL_BUSY_RISE: begin
        st_nxt = step_busy_rise(st_r, busy);
      end
      ASL_BUSY_FALL: begin
        st_nxt = step_busy_fall(st_r, busy);
      end
      ASL_GAP: begin
        st_nxt = step_gap(st_r);
      end
    endcase
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= HOST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  // Straight from the register, so no decode glitch reaches the device
  assign angle_out = st_r.angle;
  assign strobe = st_r.strobe;
  assign timeout_err = st_r.err;
endmodule

/* File: bench/asl_host_sva.sv */
// Checker for the angle strobe load host
`timescale 1ns/1ps
module asl_host_sva import asl_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ANGLE_W-1:0] src_angle,
  input wire logic [POLE_W-1:0] pole_shift,
  input wire logic reverse,
  input wire logic load_ack,
  input wire logic busy,
  input wire logic [ANGLE_W-1:0] angle_out,
  input wire logic strobe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [ANGLE_W-1:0] fa;
  int gap;
  assign fa = ((src_angle << pole_shift) ^ {ANGLE_W{reverse}}) + ANGLE_W'(reverse);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap <= 99;
    end else if (strobe) begin
      gap <= 0;
    end else begin
      gap <= gap + 1;
    end
  end
  property p_wid; $rose(strobe) |=> strobe ##1 strobe; endproperty
  a_wid: assert property (p_wid) else $error("strobe short");
  property p_gap; $rose(strobe) |-> gap > 68; endproperty
  a_gap: assert property (p_gap) else $error("strobe gap");
  property p_frm; load_ack |=> angle_out == $past(fa); endproperty
  a_frm: assert property (p_frm) else $error("angle form");
  property p_stb; busy |-> $stable(angle_out); endproperty
  a_stb: assert property (p_stb) else $error("angle moved");
  property p_nob; $rose(strobe) |-> !busy; endproperty
  a_nob: assert property (p_nob) else $error("strobe in busy");
  property p_ref; (strobe || busy) |-> !load_ack; endproperty
  a_ref: assert property (p_ref) else $error("take in busy");
endmodule

/* File: bench/asl_dev.sv */
// Behavioural converter answering the strobe with busy
`timescale 1ns/1ps
module asl_dev import asl_pkg::*; (
  input wire logic strobe,
  input wire logic [ANGLE_W-1:0] angle,
  input wire logic mute,
  input wire logic [11:0] busy_ns,
  output logic busy,
  output logic [ANGLE_W-1:0] cnt_r
);
  initial begin
    busy = 1'b0;
    cnt_r = '0;
    #1;
    forever begin
      @(negedge strobe);
      cnt_r = angle;
      if (!mute) begin
        #30 busy = 1'b1;
        #(busy_ns) busy = 1'b0;
      end
    end
  end
endmodule

/* File: bench/angle_strobe_load_interface_bench.sv */
// Testbench for the angle strobe load host
`timescale 1ns/1ps
module angle_strobe_load_interface_bench import asl_pkg::*;;
  logic clk, rst_n, reverse, load_req, load_ack, busy, strobe, terr, mute;
  logic [ANGLE_W-1:0] src_angle, angle_out, cnt;
  logic [POLE_W-1:0] pole_shift;
  logic [11:0] bns;
  int err_count, samples_checked, cyc;
  asl_host asl_host_inst (.clk(clk), .rst_n(rst_n), .src_angle(src_angle),
    .pole_shift(pole_shift), .reverse(reverse), .load_req(load_req), .load_ack(load_ack),
    .busy(busy), .angle_out(angle_out), .strobe(strobe), .timeout_err(terr));
  asl_dev asl_dev_inst (.strobe(strobe), .angle(angle_out), .mute(mute), .busy_ns(bns),
    .busy(busy), .cnt_r(cnt));
  task automatic chk(string n, logic [11:0] e, logic [11:0] s);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic results;
    $display("checked %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic load(logic [11:0] a, logic [1:0] s, logic r);
    logic [11:0] e;
    e = a << s;
    if (r) e = -e;
    @(negedge clk);
    {src_angle, pole_shift, reverse, load_req} = {a, s, r, 1'b1};
    for (int i = 0; i < 200; i++) begin
      #1;
      if (load_ack === 1'b1) break;
      @(negedge clk);
    end
    @(negedge clk);
    load_req = 1'b0;
    @(negedge strobe);
    #1 chk("angle", e, cnt);
  endtask
  task automatic t_table;
    for (int k = 0; k < 8; k++) load(12'(12'hA5C + k), k[1:0], k[2]);
    $display("table done");
  endtask
  task automatic t_speed;
    bns = 12'h9C4;
    load(12'hFFF, 2'h3, 1'b1);
    repeat (66) @(negedge clk);
    chk("busy long", 12'h000, {11'h000, terr});
    bns = 12'h6A4;
    load(12'h801, 2'h1, 1'b0);
    $display("speed done");
  endtask
  task automatic t_mute;
    mute = 1'b1;
    load(12'h123, 2'h0, 1'b1);
    repeat (66) @(negedge clk);
    chk("timeout", 12'h001, {11'h000, terr});
    mute = 1'b0;
    load(12'h456, 2'h2, 1'b0);
    chk("timeout clear", 12'h000, {11'h000, terr});
    $display("mute done");
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) if (++cyc == 8000) begin
    err_count++;
    results();
  end
  initial begin
    {rst_n, load_req, mute, src_angle, pole_shift, reverse} = '0;
    bns = 12'h7D0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    t_table();
    t_speed();
    t_mute();
    results();
  end
endmodule
bind asl_host asl_host_sva asl_host_sva_inst (.clk(clk), .rst_n(rst_n), .src_angle(src_angle),
  .pole_shift(pole_shift), .reverse(reverse), .load_ack(load_ack), .busy(busy),
  .angle_out(angle_out), .strobe(strobe));
